/* src/uart_core_defs.svh */
`ifndef UART_CORE_DEFS_SVH
`define UART_CORE_DEFS_SVH
// oversample phase counter: sixteen ticks per bit, midbit after eight
`define TICK_LAST 4'hF
`define TICK_MID 4'h7
// last index of an 8-bit data word
`define BIT_LAST 3'h7
// general pin modes, two bits per pin
`define GPIO_IN 2'h0
`define GPIO_PP 2'h1
`define GPIO_OD 2'h2
`define GPIO_EVT 2'h3
`endif

/* src/uart_core_pkg.sv */
`default_nettype none
package uart_core_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } txState_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } rxState_t;
endpackage
`default_nettype wire

/* src/host_bridged_uart_core.sv */
`include "uart_core_defs.svh"
`default_nettype none

// two-entry buffer, every output a flip-flop
module uart_buf2 #(parameter int WIDTH = 8) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot1;
  logic push;
  logic pop;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // inReady doubles as "second slot free"
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      inReady <= 1'b1;
      outData <= '0;
      slot1 <= '0;
    end else if (push && !pop) begin
      if (!outValid) begin
        outData <= inData;
        outValid <= 1'b1;
      end else begin
        slot1 <= inData;
        inReady <= 1'b0;
      end
    end else if (pop && !push) begin
      outData <= slot1;
      outValid <= !inReady;
      inReady <= 1'b1;
    end else if (pop && push) begin
      outData <= inData;
    end
  end
endmodule

// array fifo, oldest word out first
module uart_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 128) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  always_ff @(posedge core_clk) begin
    if (inValid && inReady) begin
      mem[wrPtr] <= inData;
    end
  end
  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (inValid && inReady) wrPtr <= wrPtr + 1'b1;
      if (outValid && outReady) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(inValid && inReady) - (AW+1)'(outValid && outReady);
    end
  end
endmodule

module host_bridged_uart_core
  import uart_core_pkg::*;
#(parameter int FIFO_DEPTH = 128) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hostSelectPin,
  input wire logic selectOrAddrBit0,
  input wire logic serialInOrAddrBit1,
  output logic spiMode,
  output logic [1:0] i2cAddr,
  output logic spiSerialIn,
  input wire logic [7:0] thrData,
  input wire logic thrValid,
  output logic thrReady,
  output logic [7:0] rhrData,
  output logic rhrValid,
  input wire logic rhrReady,
  input wire logic lineCtrlRts,
  input wire logic parityEnable,
  input wire logic parityOdd,
  input wire logic twoStop,
  input wire logic autoCts,
  input wire logic rxDisable,
  input wire logic refSelect,
  input wire logic refClkPin,
  input wire logic [5:0] clkPrescale,
  input wire logic [15:0] baudDivisor,
  input wire logic [7:0] gpioMode,
  input wire logic [3:0] gpioDrive,
  input wire logic [3:0] gpioEventClear,
  input wire logic powerUpAck,
  input wire logic [3:0] generalPinIn,
  output logic [3:0] generalPinOut,
  output logic [3:0] generalPinOe,
  output logic [3:0] gpioLevel,
  output logic [3:0] gpioEvent,
  input wire logic rxPin,
  output logic txLine,
  input wire logic ctsNPin,
  output logic rtsN,
  output logic ctsStatus,
  output logic irqNOut,
  output logic irqNOe
);
  logic hostMeta, hostSync, a0Meta, a0Sync, a1Meta, a1Sync;
  logic refMeta, refSync, refPrev, rxMeta, rxSync, rxPrev, ctsMeta, ctsSync;
  logic [3:0] gpioMeta, gpioSync, gpioPrev;
  logic [5:0] preCnt;
  logic [15:0] divCnt;
  logic tick16, srcEvent;
  txState_t txState;
  rxState_t rxState;
  logic [3:0] txTick, rxTick;
  logic [2:0] txBit, rxBit;
  logic [7:0] txShift, rxShift;
  logic txPar, rxPush, powerUp, txPop, ctsOk;
  logic bufValid, bufReady, txValid, rxFifoValid, rxFifoReady;
  logic [7:0] bufData, txData, rxFifoData;
  logic [$clog2(FIFO_DEPTH):0] txCount;

  // every pin passes two flops before use
  always_ff @(posedge core_clk) begin
    {hostMeta, a0Meta, a1Meta, refMeta, rxMeta, ctsMeta} <=
      {hostSelectPin, selectOrAddrBit0, serialInOrAddrBit1, refClkPin, rxPin, ctsNPin};
    {hostSync, a0Sync, a1Sync, refSync, rxSync, ctsSync} <=
      {hostMeta, a0Meta, a1Meta, refMeta, rxMeta, ctsMeta};
    {refPrev, rxPrev} <= {refSync, rxSync};
    gpioMeta <= generalPinIn;
    gpioSync <= gpioMeta;
    gpioPrev <= gpioSync;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      spiMode <= 1'b0;
      i2cAddr <= 2'h0;
      spiSerialIn <= 1'b0;
    end else begin
      spiMode <= hostSync;
      i2cAddr <= hostSync ? 2'h0 : {a1Sync, a0Sync};
      spiSerialIn <= hostSync && a1Sync;
    end
  end

  // prescaler then divisor; reference edges or core clock as source
  assign srcEvent = refSelect ? (refSync && !refPrev) : 1'b1;
  // held in reset the tick never fires
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preCnt <= '0;
      divCnt <= '0;
      tick16 <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (srcEvent) begin
        if (preCnt >= clkPrescale) begin
          preCnt <= '0;
          if (divCnt >= baudDivisor) begin
            divCnt <= '0;
            tick16 <= 1'b1;
          end else begin
            divCnt <= divCnt + 16'h0001;
          end
        end else begin
          preCnt <= preCnt + 6'h01;
        end
      end
    end
  end

  // holding words are one flat set of 8-bit values
  // holding buffer then transmit fifo, no host action needed
  uart_buf2 #(.WIDTH(8)) thrBuf (.core_clk(core_clk), .rst_n(rst_n),
    .inValid(thrValid), .inReady(thrReady), .inData(thrData),
    .outValid(bufValid), .outReady(bufReady), .outData(bufData));
  uart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (.core_clk(core_clk), .rst_n(rst_n),
    .inValid(bufValid), .inReady(bufReady), .inData(bufData),
    .outValid(txValid), .outReady(txPop), .outData(txData), .count(txCount));

  // partner's clear-to-send gates new frames when enabled
  assign ctsOk = !autoCts || !ctsSync;
  assign txPop = txState == TX_IDLE && txValid && tick16 && ctsOk;

  // transmit framer, bit boundaries every sixteen ticks
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txState <= TX_IDLE;
      txLine <= 1'b1;
      txTick <= '0;
      txBit <= '0;
      txShift <= '0;
      txPar <= 1'b0;
    end else begin
      unique case (txState)
        TX_IDLE: begin
          txLine <= 1'b1;
          txTick <= '0;
          if (txPop) begin
            txShift <= txData;
            txPar <= parityOdd;
            txLine <= 1'b0;
            txState <= TX_START;
          end
        end
        default: begin
          if (tick16) begin
            txTick <= txTick + 4'h1;
            if (txTick == `TICK_LAST) begin
              if (txState == TX_START || (txState == TX_DATA && txBit != `BIT_LAST)) begin
                txLine <= txShift[0];
                txPar <= txPar ^ txShift[0];
                txShift <= {1'b0, txShift[7:1]};
                txBit <= txState == TX_START ? 3'h0 : txBit + 3'h1;
                txState <= TX_DATA;
              end else if (txState == TX_DATA && parityEnable) begin
                txLine <= txPar;
                txState <= TX_PAR;
              end else if (txState != TX_STOP) begin
                txLine <= 1'b1;
                txBit <= 3'h0;
                txState <= TX_STOP;
              end else if (twoStop && txBit == 3'h0) begin
                txBit <= 3'h1;
              end else begin
                txState <= TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // receiver: midbit samples, lsb first, stop must be high
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxState <= RX_IDLE;
      rxTick <= '0;
      rxBit <= '0;
      rxShift <= '0;
      rxPush <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      unique case (rxState)
        RX_IDLE: begin
          rxTick <= '0;
          if (rxPrev && !rxSync && !rxDisable) rxState <= RX_START;
        end
        RX_START: if (tick16) begin
          rxTick <= rxTick + 4'h1;
          if (rxTick == `TICK_MID) begin
            rxTick <= '0;
            rxBit <= '0;
            rxState <= rxSync ? RX_IDLE : RX_DATA; // glitch, not a start
          end
        end
        default: if (tick16) begin
          rxTick <= rxTick + 4'h1;
          if (rxTick == `TICK_LAST) begin
            if (rxState == RX_DATA) begin
              rxShift <= {rxSync, rxShift[7:1]};
              rxBit <= rxBit + 3'h1;
              if (rxBit == `BIT_LAST) rxState <= parityEnable ? RX_PAR : RX_STOP;
            end else if (rxState == RX_PAR) begin
              rxState <= RX_STOP;
            end else begin
              // only a properly framed word is queued
              rxPush <= rxSync;
              rxState <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // receive fifo drained through the holding buffer
  uart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (.core_clk(core_clk), .rst_n(rst_n),
    .inValid(rxPush), .inReady(), .inData(rxShift),
    .outValid(rxFifoValid), .outReady(rxFifoReady), .outData(rxFifoData), .count());
  uart_buf2 #(.WIDTH(8)) rhrBuf (.core_clk(core_clk), .rst_n(rst_n),
    .inValid(rxFifoValid), .inReady(rxFifoReady), .inData(rxFifoData),
    .outValid(rhrValid), .outReady(rhrReady), .outData(rhrData));

  // flow pins; request-to-send is active low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rtsN <= 1'b1;
      ctsStatus <= 1'b0;
    end else begin
      rtsN <= !lineCtrlRts;
      ctsStatus <= !ctsSync;
    end
  end

  // per-pin mode; an event set beats a same-cycle clear
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          generalPinOut[i] <= 1'b0;
          generalPinOe[i] <= 1'b0;
          gpioLevel[i] <= 1'b0;
          gpioEvent[i] <= 1'b0;
        end else begin
          generalPinOut[i] <= gpioMode[2*i+:2] == `GPIO_PP && gpioDrive[i];
          generalPinOe[i] <= gpioMode[2*i+:2] == `GPIO_PP ||
                             (gpioMode[2*i+:2] == `GPIO_OD && !gpioDrive[i]);
          gpioLevel[i] <= gpioSync[i];
          if (gpioMode[2*i+:2] == `GPIO_EVT && gpioSync[i] != gpioPrev[i])
            gpioEvent[i] <= 1'b1;
          else if (gpioEventClear[i])
            gpioEvent[i] <= 1'b0;
        end
      end
      property p_gpio_od;
        @(posedge core_clk) disable iff (!rst_n)
        (gpioMode[2*i+:2] == `GPIO_OD) |=> !generalPinOut[i] &&
          (generalPinOe[i] == !$past(gpioDrive[i]));
      endproperty
      a_gpio_od: assert property (p_gpio_od) else $error("open-drain pin misdriven");
    end
  endgenerate

  // open-drain interrupt, also asserted from power-up until acknowledged
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      powerUp <= 1'b1;
      irqNOut <= 1'b0;
      irqNOe <= 1'b1;
    end else begin
      if (powerUpAck) powerUp <= 1'b0;
      irqNOut <= 1'b0;
      irqNOe <= powerUp || rhrValid || (|gpioEvent);
    end
  end

  property p_sel;
    @(posedge core_clk) disable iff (!rst_n)
    hostSync |=> spiMode && i2cAddr == 2'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("select pin not honoured");
  property p_addr;
    @(posedge core_clk) disable iff (!rst_n)
    !hostSync |=> i2cAddr[1] == $past(a1Sync) && !spiSerialIn;
  endproperty
  a_addr: assert property (p_addr) else $error("address bit1 wrong");
  property p_rts;
    @(posedge core_clk) disable iff (!rst_n)
    $changed(lineCtrlRts) |=> rtsN == !$past(lineCtrlRts);
  endproperty
  a_rts: assert property (p_rts) else $error("request-to-send wrong");
  property p_thr;
    @(posedge core_clk) disable iff (!rst_n)
    thrValid && thrReady |=> ##[0:3] (txCount != '0 || txState != TX_IDLE);
  endproperty
  a_thr: assert property (p_thr) else $error("written byte not queued");
  property p_start;
    @(posedge core_clk) disable iff (!rst_n)
    txPop |=> txState == TX_START && !txLine && txShift == $past(txData);
  endproperty
  a_start: assert property (p_start) else $error("start bit missing");
  property p_fall;
    @(posedge core_clk) disable iff (!rst_n)
    rxState == RX_IDLE && rxPrev && !rxSync && !rxDisable |=> rxState == RX_START;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  property p_idle;
    @(posedge core_clk) disable iff (!rst_n)
    txState == TX_IDLE && !txPop |=> txLine;
  endproperty
  a_idle: assert property (p_idle) else $error("transmit line not idle");
  property p_rst;
    @(posedge core_clk)
    !rst_n |=> !tick16 && txLine && txState == TX_IDLE && irqNOe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_irq;
    @(posedge core_clk) disable iff (!rst_n)
    powerUp || rhrValid |=> irqNOe && !irqNOut;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not asserted");
endmodule
`default_nettype wire

/* sim/uart_link_partner.sv */
`default_nettype none
module uart_link_partner (
  input wire logic core_clk,
  input wire logic txLine,
  output logic rxPin,
  output logic ctsNPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // one tick per core clock, so sixteen clocks per bit
  localparam int BIT_CYC = 16;
  // line idles high, as its pull-up would leave it
  initial begin
    rxPin = 1'b1;
    ctsNPin = 1'b0;
  end
  task automatic set_cts(input logic allow);
    ctsNPin <= !allow;
  endtask
  task automatic send_bit(input logic level);
    rxPin <= level;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask
  task automatic send_byte(input logic [7:0] d, input logic parEn, input logic parOdd);
    // every level change lands on a rising edge
    @(posedge core_clk);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      send_bit(d[i]);
    end
    if (parEn) begin
      send_bit(^d ^ parOdd);
    end
    send_bit(1'b1);
  endtask
  // bit centres sampled on the falling edge, clear of the launch edge
  task automatic capture(input logic parEn, output logic [7:0] d, output logic par,
                         output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    par = 1'b0;
    while (txLine !== 1'b0 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge core_clk);
    ok = (txLine === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge core_clk);
      d[i] = txLine;
    end
    if (parEn) begin
      repeat (BIT_CYC) @(negedge core_clk);
      par = txLine;
    end
    repeat (BIT_CYC) @(negedge core_clk);
    ok = ok && (txLine === 1'b1);
  endtask
endmodule
`default_nettype wire

/* sim/host_bridged_uart_core_tb_top.sv */
`include "uart_core_defs.svh"
`default_nettype none
module host_bridged_uart_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // small fifo so the fill test stays short
  localparam int DEPTH = 4;
  typedef struct packed {
    logic [7:0] data;
    logic parEn;
    logic parOdd;
    logic twoStop;
    logic expPar;
  } row_t;
  row_t rows [5] = '{'{8'hA5, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h3C, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h81, 1'b1, 1'b1, 1'b0, 1'b1}, '{8'h00, 1'b1, 1'b1, 1'b1, 1'b1},
    '{8'hFF, 1'b1, 1'b0, 1'b1, 1'b0}};
  logic core_clk, rst_n, hostSelectPin, selectOrAddrBit0, serialInOrAddrBit1;
  logic spiMode, spiSerialIn, thrValid, thrReady, rhrValid, rhrReady, lineCtrlRts;
  logic parityEnable, parityOdd, twoStop, autoCts, powerUpAck, rxPin, txLine, ctsNPin;
  logic rtsN, ctsStatus, irqNOut, irqNOe, taken, ok, gotP;
  logic rxOff, refSel, refClk;
  logic [1:0] i2cAddr;
  logic [7:0] thrData, rhrData, gpioMode, gotD;
  logic [3:0] gpioDrive, gpioEventClear, pinDrv, generalPinIn, generalPinOut;
  logic [3:0] generalPinOe, gpioLevel, gpioEvent;
  int err_total, check_count, k;
  // pin wire: design drive wins where enabled, else the outside level
  assign generalPinIn = (generalPinOe & generalPinOut) | (~generalPinOe & pinDrv);
  host_bridged_uart_core #(.FIFO_DEPTH(DEPTH)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .hostSelectPin(hostSelectPin), .selectOrAddrBit0(selectOrAddrBit0),
    .serialInOrAddrBit1(serialInOrAddrBit1), .spiMode(spiMode), .i2cAddr(i2cAddr),
    .spiSerialIn(spiSerialIn), .thrData(thrData), .thrValid(thrValid), .thrReady(thrReady),
    .rhrData(rhrData), .rhrValid(rhrValid), .rhrReady(rhrReady), .lineCtrlRts(lineCtrlRts),
    .parityEnable(parityEnable), .parityOdd(parityOdd), .twoStop(twoStop), .autoCts(autoCts),
    .rxDisable(rxOff), .refSelect(refSel), .refClkPin(refClk), .clkPrescale(6'h00),
    .baudDivisor(16'h0000), .gpioMode(gpioMode), .gpioDrive(gpioDrive),
    .gpioEventClear(gpioEventClear), .powerUpAck(powerUpAck), .generalPinIn(generalPinIn),
    .generalPinOut(generalPinOut), .generalPinOe(generalPinOe), .gpioLevel(gpioLevel),
    .gpioEvent(gpioEvent), .rxPin(rxPin), .txLine(txLine), .ctsNPin(ctsNPin), .rtsN(rtsN),
    .ctsStatus(ctsStatus), .irqNOut(irqNOut), .irqNOe(irqNOe));
  uart_link_partner u_partner (.core_clk(core_clk), .txLine(txLine), .rxPin(rxPin),
    .ctsNPin(ctsNPin));
  // 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = !core_clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // caller stands just after a rising edge; valid stays up for back-to-back use
  task automatic write_thr(input logic [7:0] d, input int limit, output logic took);
    int n;
    n = 0;
    thrData <= d;
    thrValid <= 1'b1;
    @(negedge core_clk);
    while (thrReady !== 1'b1 && n < limit) begin
      @(negedge core_clk);
      n++;
    end
    took = (thrReady === 1'b1);
    @(posedge core_clk);
  endtask
  task automatic read_rhr(output logic [7:0] d);
    int n;
    n = 0;
    rhrReady <= 1'b1;
    @(negedge core_clk);
    while (rhrValid !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    d = rhrData;
    @(posedge core_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog: whole run needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
  initial begin
    {rst_n, hostSelectPin, selectOrAddrBit0, serialInOrAddrBit1, thrValid, rhrReady} = '0;
    {lineCtrlRts, parityEnable, parityOdd, twoStop, autoCts, powerUpAck} = '0;
    {thrData, gpioMode, gpioDrive, gpioEventClear, pinDrv} = '0;
    {rxOff, refSel, refClk} = '0;
    err_total = 0;
    check_count = 0;
    settle(7);
    chk("reset lines", 8'h07, {txLine, rtsN, thrReady});
    chk("reset flags", 8'h02, {rhrValid, irqNOe, spiMode});
    chk("reset pin oe", 8'h00, generalPinOe);
    @(posedge core_clk);
    rst_n <= 1'b1;
    powerUpAck <= 1'b1;
    @(posedge core_clk);
    powerUpAck <= 1'b0;
    settle(4);
    chk("irq after ack", 8'h00, irqNOe);
    chk("irq level", 8'h00, irqNOut);
    $display("test reset done");
    for (int r = 0; r < 5; r++) begin
      @(posedge core_clk);
      {parityEnable, parityOdd, twoStop} <= {rows[r].parEn, rows[r].parOdd, rows[r].twoStop};
      @(posedge core_clk);
      write_thr(rows[r].data, 50, taken);
      thrValid <= 1'b0;
      u_partner.capture(rows[r].parEn, gotD, gotP, ok);
      chk("tx data", rows[r].data, gotD);
      chk("tx parity", rows[r].expPar, gotP);
      chk("tx framing", 8'h01, ok);
      settle(32);
      chk("tx idle", 8'h01, txLine);
      u_partner.send_byte(rows[r].data, rows[r].parEn, rows[r].parOdd);
      read_rhr(gotD);
      rhrReady <= 1'b0;
      chk("rx data", rows[r].data, gotD);
    end
    $display("test frame rows done");
    @(posedge core_clk);
    lineCtrlRts <= 1'b1;
    settle(3);
    chk("rts low", 8'h00, rtsN);
    @(posedge core_clk);
    lineCtrlRts <= 1'b0;
    selectOrAddrBit0 <= 1'b1;
    settle(5);
    chk("rts high", 8'h01, rtsN);
    chk("i2c addr", 8'h01, {spiMode, i2cAddr});
    @(posedge core_clk);
    {selectOrAddrBit0, serialInOrAddrBit1} <= 2'h1;
    settle(5);
    chk("i2c addr bit1", 8'h02, {spiMode, i2cAddr});
    @(posedge core_clk);
    hostSelectPin <= 1'b1;
    settle(5);
    chk("spi mode", 8'h09, {spiMode, i2cAddr, spiSerialIn});
    $display("test pins done");
    @(posedge core_clk);
    gpioMode <= {`GPIO_EVT, `GPIO_OD, `GPIO_PP, `GPIO_IN};
    gpioDrive <= 4'hF;
    pinDrv <= 4'h1;
    settle(5);
    chk("oe drive high", 8'h02, generalPinOe);
    chk("level drive high", 8'h03, gpioLevel);
    chk("out drive high", 8'h02, generalPinOut);
    @(posedge core_clk);
    gpioDrive <= 4'h0;
    settle(5);
    chk("oe drive low", 8'h06, generalPinOe);
    chk("level drive low", 8'h01, gpioLevel);
    chk("out drive low", 8'h00, generalPinOut);
    @(posedge core_clk);
    pinDrv <= 4'h9;
    settle(5);
    chk("event set", 8'h01, gpioEvent[3]);
    chk("event irq", 8'h01, irqNOe);
    @(posedge core_clk);
    gpioEventClear <= 4'h8;
    @(posedge core_clk);
    gpioEventClear <= 4'h0;
    settle(3);
    chk("event cleared", 8'h00, {gpioEvent[3], irqNOe});
    $display("test general pins done");
    // blocked partner: fill until refused, then drain in order
    @(posedge core_clk);
    {autoCts, parityEnable, twoStop} <= 3'h4;
    u_partner.set_cts(1'b0);
    settle(5);
    chk("cts blocked", 8'h00, ctsStatus);
    @(posedge core_clk);
    k = 0;
    taken = 1'b1;
    while (taken && k < 20) begin
      write_thr(8'(8'h40 + k), 4, taken);
      k += int'(taken);
    end
    thrValid <= 1'b0;
    // fifo words plus the two holding slots are accepted, then refused
    chk("fill count", 8'(DEPTH + 2), 8'(k));
    chk("tx held", 8'h01, txLine);
    u_partner.set_cts(1'b1);
    for (int i = 0; i < k; i++) begin
      u_partner.capture(1'b0, gotD, gotP, ok);
      chk("drain order", 8'(8'h40 + i), gotD);
    end
    chk("cts allowed", 8'h01, ctsStatus);
    $display("test fill and drain done");
    // receiver stalled while three words queue
    for (int i = 0; i < 3; i++) begin
      u_partner.send_byte(8'(8'hC1 + i), 1'b0, 1'b0);
    end
    settle(8);
    chk("rx irq", 8'h01, irqNOe);
    @(posedge core_clk);
    for (int i = 0; i < 3; i++) begin
      read_rhr(gotD);
      chk("rx oldest first", 8'(8'hC1 + i), gotD);
    end
    rhrReady <= 1'b0;
    settle(4);
    chk("rx drained", 8'h00, {rhrValid, irqNOe});
    $display("test receive queue done");
    // reference source: no edges means no ticks, one edge gives one tick
    @(posedge core_clk);
    refSel <= 1'b1;
    settle(4);
    @(posedge core_clk);
    write_thr(8'h5A, 50, taken);
    thrValid <= 1'b0;
    settle(40);
    chk("ref stopped", 8'h01, txLine);
    @(posedge core_clk);
    refClk <= 1'b1;
    settle(8);
    chk("ref edge tick", 8'h00, txLine);
    @(posedge core_clk);
    refSel <= 1'b0;
    u_partner.capture(1'b0, gotD, gotP, ok);
    chk("ref frame", 8'h5A, gotD);
    $display("test reference clock done");
    // receiver switched off ignores a whole frame
    @(posedge core_clk);
    rxOff <= 1'b1;
    u_partner.send_byte(8'h77, 1'b0, 1'b0);
    rxOff <= 1'b0;
    settle(20);
    chk("rx off", 8'h00, rhrValid);
    $display("test receiver off done");
    finish_test();
  end
endmodule
`default_nettype wire
